// ### rtl/timer_prescaler_regs.svh
// Offsets, field positions, reset values and tap figures for the shared prescaler
`ifndef TIMER_PRESCALER_REGS_SVH
`define TIMER_PRESCALER_REGS_SVH
`define GTC_ADDR         4'h0
`define STATUS_ADDR      4'h1
`define TSEL_ADDR        4'h2
`define GTC_SYNC_BIT     7
`define GTC_ASYNC_BIT    1
`define GTC_SHARED_BIT   0
`define GTC_RESET        8'h00
`define TSEL_RESET       8'h00
`define DIV_WIDTH        10
`define TAP8_BIT         2
`define TAP64_BIT        5
`define TAP256_BIT       7
`define TAP1024_BIT      9
`define SRC_STOP         3'h0
`define SRC_DIRECT       3'h1
`define SRC_DIV8         3'h2
`define SRC_DIV64        3'h3
`define SRC_DIV256       3'h4
`define SRC_DIV1024      3'h5
`define SRC_FALL         3'h6
`define SRC_RISE         3'h7
`endif

// ### rtl/timer_prescaler_pkg.sv
// Types shared by the prescaler and clock-select logic
package timer_prescaler_pkg;
  typedef logic [2:0] tick_source_select_t;
  typedef struct packed {
    logic div8;
    logic div64;
    logic div256;
    logic div1024;
  } tap_pulses_s;
  typedef struct packed {
    logic rise;
    logic fall;
  } pin_edges_s;
endpackage

// ### rtl/count_pin_sync.sv
// Count pin synchroniser and edge detector
`timescale 1ns/10ps
`include "timer_prescaler_regs.svh"
module count_pin_sync (
  input  wire logic                           clk,
  input  wire logic                           rst,
  input  wire logic                           externalCountPin,
  output timer_prescaler_pkg::pin_edges_s     edges
);
  logic frontReg;
  logic syncReg;
  logic lastReg;

  always_ff @(posedge clk) begin
    if (rst) begin
      frontReg <= 1'b0;
      syncReg  <= 1'b0;
      lastReg  <= 1'b0;
    end else begin
      frontReg <= externalCountPin;
      syncReg  <= frontReg;
      lastReg  <= syncReg;
    end
  end

  always_comb begin
    edges.rise = syncReg & ~lastReg;
    edges.fall = ~syncReg & lastReg;
  end
endmodule // count_pin_sync

// ### rtl/shared_divider.sv
// Free-running divider with prescaled tick taps
`timescale 1ns/10ps
`include "timer_prescaler_regs.svh"
module shared_divider (
  input  wire logic                           clk,
  input  wire logic                           rst,
  input  wire logic                           dividerReset,
  output timer_prescaler_pkg::tap_pulses_s    taps
);
  logic [`DIV_WIDTH-1:0] countReg;
  logic [`DIV_WIDTH-1:0] countNext;

  always_ff @(posedge clk) begin
    if (rst || dividerReset) begin
      countReg <= '0;
    end else begin
      countReg <= countNext;
    end
  end

  always_comb begin
    countNext = countReg + `DIV_WIDTH'(1);
  end

  // Taps fire when low bits all ones and dividerReset is low
  always_comb begin
    taps.div8    = &countReg[`TAP8_BIT:0] & ~dividerReset;
    taps.div64   = &countReg[`TAP64_BIT:0] & ~dividerReset;
    taps.div256  = &countReg[`TAP256_BIT:0] & ~dividerReset;
    taps.div1024 = &countReg[`TAP1024_BIT:0] & ~dividerReset;
  end
endmodule // shared_divider

// ### rtl/shared_timer_prescaler_sync.sv
// Shared prescaler, count pin logic and general timer control register
//
// Implementation choices: the address-and-strobe port and the address map.
`timescale 1ns/10ps
`include "timer_prescaler_regs.svh"
module shared_timer_prescaler_sync (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [3:0] regAddr,
  input  wire logic [7:0] regWriteData,
  input  wire logic       regWriteStrobe,
  input  wire logic       regReadStrobe,
  output logic [7:0]      regReadData,
  input  wire logic       externalCountPin0,
  input  wire logic       externalCountPin1,
  output logic            timerTick0,
  output logic            timerTick1,
  output logic            asyncDividerReset
);
  timer_prescaler_pkg::tap_pulses_s          taps;
  timer_prescaler_pkg::pin_edges_s           edges0;
  timer_prescaler_pkg::pin_edges_s           edges1;
  timer_prescaler_pkg::tick_source_select_t  tickSourceSelect0Reg;
  timer_prescaler_pkg::tick_source_select_t  tickSourceSelect1Reg;
  logic                                      syncHoldModeReg;
  logic                                      sharedDividerResetReg;
  logic                                      asyncDividerResetReg;
  logic                                      gtcWrite;
  logic                                      tselWrite;
  logic [7:0]                                readNext;

  assign gtcWrite  = regWriteStrobe && (regAddr == `GTC_ADDR);
  assign tselWrite = regWriteStrobe && (regAddr == `TSEL_ADDR);

  always_ff @(posedge clk) begin
    if (rst) begin
      syncHoldModeReg <= 1'b0;
    end else if (gtcWrite) begin
      syncHoldModeReg <= regWriteData[`GTC_SYNC_BIT];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      sharedDividerResetReg <= 1'b0;
    end else if (gtcWrite) begin
      sharedDividerResetReg <= regWriteData[`GTC_SHARED_BIT] & regWriteData[`GTC_SYNC_BIT];
    end else if (!syncHoldModeReg) begin
      sharedDividerResetReg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      asyncDividerResetReg <= 1'b0;
    end else if (gtcWrite) begin
      asyncDividerResetReg <= regWriteData[`GTC_ASYNC_BIT] & regWriteData[`GTC_SYNC_BIT];
    end else if (!syncHoldModeReg) begin
      asyncDividerResetReg <= 1'b0;
    end
  end

  // Write pulse resets even outside sync mode; held bit resets while in it
  logic dividerReset;
  logic asyncPulse;
  assign dividerReset      = sharedDividerResetReg | (gtcWrite & regWriteData[`GTC_SHARED_BIT]);
  assign asyncPulse        = gtcWrite & regWriteData[`GTC_ASYNC_BIT];
  assign asyncDividerReset = asyncDividerResetReg | asyncPulse;

  always_ff @(posedge clk) begin
    if (rst) begin
      tickSourceSelect0Reg <= `SRC_STOP;
      tickSourceSelect1Reg <= `SRC_STOP;
    end else if (tselWrite) begin
      tickSourceSelect0Reg <= regWriteData[2:0];
      tickSourceSelect1Reg <= regWriteData[6:4];
    end
  end

  shared_divider divider (
    .clk          (clk),
    .rst          (rst),
    .dividerReset (dividerReset),
    .taps         (taps)
  );

  count_pin_sync pinSync0 (
    .clk              (clk),
    .rst              (rst),
    .externalCountPin (externalCountPin0),
    .edges            (edges0)
  );

  count_pin_sync pinSync1 (
    .clk              (clk),
    .rst              (rst),
    .externalCountPin (externalCountPin1),
    .edges            (edges1)
  );

  function automatic logic pickTick(
    input timer_prescaler_pkg::tick_source_select_t sel,
    input timer_prescaler_pkg::tap_pulses_s         tp,
    input timer_prescaler_pkg::pin_edges_s          ed,
    input logic                                     held
  );
    logic t;
    t = 1'b0;
    case (sel)
      `SRC_STOP:    t = 1'b0;
      `SRC_DIRECT:  t = 1'b1;
      `SRC_DIV8:    t = tp.div8;
      `SRC_DIV64:   t = tp.div64;
      `SRC_DIV256:  t = tp.div256;
      `SRC_DIV1024: t = tp.div1024;
      `SRC_FALL:    t = ed.fall;
      `SRC_RISE:    t = ed.rise;
      default:      t = 1'b0;
    endcase
    return t & ~held;
  endfunction

  // Edge reaches tick after sampling chain
  always_comb begin
    timerTick0 = pickTick(tickSourceSelect0Reg, taps, edges0, sharedDividerResetReg);
    timerTick1 = pickTick(tickSourceSelect1Reg, taps, edges1, sharedDividerResetReg);
  end

  always_comb begin
    case (regAddr)
      `GTC_ADDR:    readNext = {syncHoldModeReg, 5'h00, asyncDividerResetReg, sharedDividerResetReg};
      `STATUS_ADDR: readNext = {4'h0, edges1.rise | edges1.fall, edges0.rise | edges0.fall, timerTick1, timerTick0};
      `TSEL_ADDR:   readNext = {1'b0, tickSourceSelect1Reg, 1'b0, tickSourceSelect0Reg};
      default:      readNext = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      regReadData <= 8'h00;
    end else if (regReadStrobe) begin
      regReadData <= readNext;
    end else begin
      regReadData <= 8'h00;
    end
  end
endmodule // shared_timer_prescaler_sync

// ### tb/count_pin_driver.sv
// Pulse source standing in for the external count clock
`timescale 1ns/10ps
module count_pin_driver (
  input  wire logic       clk,
  input  wire logic       go,
  input  wire logic [3:0] pulses,
  output logic            pin
);
  logic [3:0] left = 4'h0;
  logic [1:0] ph = 2'h0;
  initial pin = 1'b0;
  always @(posedge clk) begin
    if (go) begin
      left <= pulses;
      ph <= 2'h0;
    end else if (left != 4'h0) begin
      ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
      if (ph == 2'h2) begin
        pin <= ~pin;
        left <= pin ? left - 4'h1 : left;
      end
    end
  end
endmodule // count_pin_driver

// ### tb/prescaler_properties.sv
// Port checker for the shared prescaler
`timescale 1ns/10ps
module prescaler_properties (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWriteData,
  input wire logic       regWriteStrobe,
  input wire logic       externalCountPin0,
  input wire logic       externalCountPin1,
  input wire logic       timerTick0,
  input wire logic       timerTick1,
  input wire logic       asyncDividerReset
);
  logic [2:0] s0, s1;
  logic       held, ctlWr;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  assign ctlWr = regWriteStrobe && regAddr == 4'h0;
  // Mirror of select fields and hold state
  always_ff @(posedge clk) begin
    if (rst) begin
      s0 <= 3'h0;
      s1 <= 3'h0;
      held <= 1'b0;
    end else begin
      if (regWriteStrobe && regAddr == 4'h2) begin
        s0 <= regWriteData[2:0];
        s1 <= regWriteData[6:4];
      end
      if (ctlWr) held <= regWriteData[7] & regWriteData[0];
    end
  end
  a_stop_quiet: assert property (s0 == 3'h0 |-> !timerTick0) else $error("tick unselected");
  a_direct_every: assert property (s0 == 3'h1 && !held |-> timerTick0) else $error("direct gap");
  a_div8_gap: assert property (timerTick0 && s0 == 3'h2 |=> !timerTick0 [*7]) else $error("div8 early");
  a_release_phase: assert property (ctlWr && held && regWriteData == 8'h00 && s0 == 3'h2
    |=> !timerTick0 [*7] ##1 timerTick0) else $error("release phase");
  a_hold_quiet: assert property (held |-> !timerTick0 && !timerTick1) else $error("tick held");
  a_async_held: assert property (ctlWr && regWriteData[7] && regWriteData[1] |=> asyncDividerReset)
    else $error("async not held");
  a_rise_tick: assert property ($rose(externalCountPin0) && s0 == 3'h7 && !held
    |-> ##2 timerTick0 ##1 !timerTick0) else $error("rise tick");
  a_fall_tick: assert property ($fell(externalCountPin1) && s1 == 3'h6 && !held
    |-> ##2 timerTick1 ##1 !timerTick1) else $error("fall tick");
  c_release: cover property (ctlWr && held && regWriteData == 8'h00);
  c_rise: cover property (s0 == 3'h7 && timerTick0);
  c_async: cover property (asyncDividerReset);
endmodule // prescaler_properties
bind shared_timer_prescaler_sync prescaler_properties u_props (.clk, .rst, .regAddr, .regWriteData,
  .regWriteStrobe, .externalCountPin0, .externalCountPin1, .timerTick0, .timerTick1, .asyncDividerReset);

// ### tb/tb_shared_timer_prescaler_sync.sv
// Self-checking bench for the shared prescaler
`timescale 1ns/10ps
module tb_shared_timer_prescaler_sync;
  logic       clk, rst, regWriteStrobe, regReadStrobe, rdSeen, go, pin;
  logic       timerTick0, timerTick1, asyncDividerReset;
  logic [3:0] regAddr, pulses;
  logic [7:0] regWriteData, regReadData, lfsr;
  logic [7:0] expQ[$];
  int         num_errors, compares, cycles;
  // Four-state tallies so an unknown tick cannot slip through as zero
  integer     n0, n1;
  int         taps[6] = '{0, 1024, 128, 16, 4, 1};
  count_pin_driver u_pin (.clk, .go, .pulses, .pin);
  shared_timer_prescaler_sync u_dut (.clk, .rst, .regAddr, .regWriteData, .regWriteStrobe, .regReadStrobe,
    .regReadData, .externalCountPin0(pin), .externalCountPin1(pin), .timerTick0, .timerTick1, .asyncDividerReset);
  always #10 clk = ~clk;
  function automatic logic [7:0] step(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task automatic wrap_up;
    if (num_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic fail(input logic [31:0] g, input logic [31:0] e);
    num_errors++;
    $display("unexpected at %0t: got %h expected %h", $time, g, e);
  endtask
  task automatic checkRead(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) fail(g, e);
  endtask
  task automatic checkCount(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) fail(g, e);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    regAddr <= a;
    regWriteData <= d;
    regWriteStrobe <= 1'b1;
    @(posedge clk);
    regWriteStrobe <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    regAddr <= a;
    regReadStrobe <= 1'b1;
    expQ.push_back(e);
    @(posedge clk);
    regReadStrobe <= 1'b0;
  endtask
  task automatic pulse(input logic [3:0] p);
    @(posedge clk);
    pulses <= p;
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
  endtask
  // Counts ticks at negedge, away from the launching edge
  task automatic measure(input int n, input int e0, input int e1);
    n0 = 0;
    n1 = 0;
    repeat (n) begin
      @(negedge clk);
      n0 += timerTick0;
      n1 += timerTick1;
    end
    checkCount(n0, e0);
    checkCount(n1, e1);
  endtask
  always @(posedge clk) rdSeen <= regReadStrobe;
  always @(negedge clk) if (rdSeen) checkRead(regReadData, expQ.pop_front());
  // Ceiling well above the six long windows
  always @(posedge clk) begin
    cycles++;
    if (cycles == 10000) begin
      num_errors++;
      wrap_up;
    end
  end
  initial begin
    {clk, regWriteStrobe, regReadStrobe, rdSeen, go, regAddr, pulses, regWriteData} = '0;
    rst = 1'b1;
    lfsr = 8'h4f;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    rd(4'h0, 8'h00);
    rd(4'h2, 8'h00);
    wr(4'h0, 8'h83);
    rd(4'h0, 8'h83);
    wr(4'h0, 8'h00);
    rd(4'h0, 8'h00);
    wr(4'h0, 8'h07);
    rd(4'h0, 8'h00);
    rd(4'hf, 8'h00);
    lfsr = step(lfsr);
    wr(4'h2, lfsr);
    rd(4'h2, lfsr & 8'h77);
    for (int i = 0; i < 6; i++) begin
      wr(4'h0, 8'h81);
      wr(4'h2, {1'b0, 3'(5 - i), 1'b0, 3'(i)});
      wr(4'h0, 8'h00);
      measure(1024, taps[i], taps[5 - i]);
    end
    wr(4'h2, 8'h67);
    lfsr = step(lfsr);
    pulse({1'b0, lfsr[2:0]} + 4'h1);
    measure(60, lfsr[2:0] + 1, lfsr[2:0] + 1);
    wr(4'h0, 8'h81);
    pulse(4'h3);
    measure(60, 0, 0);
    wr(4'h0, 8'h00);
    wrap_up;
  end
endmodule // tb_shared_timer_prescaler_sync
